// ### hdl/spd_pkg.sv
// shared constants and types of the post-divider channel block
// assumes one 10 MHz clock and byte-wide register access
package spd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, three bytes per control word)
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W   = 24;     // control word width
  localparam int unsigned NUM_REG  = 4;      // words held here
  localparam int unsigned NUM_CHAN = 3;      // active channels a..c
  localparam int unsigned CNT_W    = 16;     // low field width
  localparam logic [7:0]  SYNTH2_CHAN_D_DIVIDER_CTRL = 8'h00_A1;
  localparam logic [7:0]  SYNTH3_CHAN_A_DIVIDER_CTRL = 8'h00_A4;
  localparam logic [7:0]  SYNTH3_CHAN_B_DIVIDER_CTRL = 8'h00_A7;
  localparam logic [7:0]  SYNTH3_CHAN_C_DIVIDER_CTRL = 8'h00_AA;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 24'h00_0000;

  // ----------------------------------------------------------------
  // field positions of a control word
  // ----------------------------------------------------------------
  localparam int unsigned TYPE_HI  = 23;     // output-type field
  localparam int unsigned TYPE_LO  = 20;
  localparam int unsigned STYLE_B  = 19;     // pulse style bit
  localparam int unsigned POL_B    = 18;     // pulse polarity bit
  localparam int unsigned SEL_HI   = 17;     // reference select
  localparam int unsigned SEL_LO   = 16;
  localparam logic [3:0]  TYPE_SPECIAL = 4'hF;   // all ones
  localparam logic [1:0]  S2D_OWN_CODE = 2'h3;   // chan d own code

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_DIV,      // regular divided clock
    MODE_LOWFREQ,  // low-frequency clock from base rate
    MODE_FRAME     // frame pulse from a sibling channel
  } spd_mode_e;

  // byte-wide register request
  typedef struct packed {
    logic [7:0] addr;    // byte address
    logic [7:0] wrData;  // write byte
    logic       write;   // write strobe
    logic       read;    // read strobe
  } spd_reg_req_s;

  // divider state
  typedef struct packed {
    logic [CTRL_W-1:0] count;  // ticks in the current half
    logic              level;  // output level
  } spd_div_s;

  // main block state
  typedef struct packed {
    logic [NUM_REG-1:0][CTRL_W-1:0]   ctrl;     // software view
    logic [NUM_REG-1:0][CTRL_W-1:0]   active;   // committed words
    logic [NUM_REG-1:0][2:0]          wrMask;   // bytes written
    logic [7:0]                       rdData;   // read byte
    logic [NUM_CHAN:0]                refLast;  // refs last cycle
    logic [NUM_CHAN-1:0][CNT_W-1:0]   frmCnt;   // ref periods
    logic [NUM_CHAN-1:0]              midPulse; // mid-style pulse
    logic [NUM_CHAN-1:0]              out;      // channel outputs
  } spd_state_s;

endpackage : spd_pkg

// ### hdl/spd_divider.sv
// 50% duty divider counting enable ticks
// assumes tick is a one-cycle enable at the source rate
module spd_divider (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      tick,
  input  wire logic [spd_pkg::CTRL_W-1:0] ratio,
  output logic                           level
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spd_pkg::spd_div_s st;       // registered state
  spd_pkg::spd_div_s next_st;  // next state
  logic [spd_pkg::CTRL_W-1:0] lowLen;   // ticks spent low
  logic [spd_pkg::CTRL_W-1:0] highLen;  // ticks spent high
  logic [spd_pkg::CTRL_W-1:0] phaseLen; // length of this half

  // odd ratios give the extra tick to the high half
  assign lowLen   = ratio >> 1;
  assign highLen  = ratio - lowLen;
  assign phaseLen = st.level ? highLen : lowLen;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (ratio < 24'h00_0002) begin
      // zero or one cannot be split in halves: hold low
      next_st.count = '0;
      next_st.level = 1'b0;
    end else if (tick) begin
      // a shrunk ratio must not strand the counter
      if (st.count >= phaseLen - 24'h00_0001) begin
        next_st.count = '0;
        next_st.level = ~st.level;
      end else begin
        next_st.count = st.count + 24'h00_0001;
      end
    end
  end

  // register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule : spd_divider

// ### hdl/spd_post_divider.sv
// post-divider channels a..c of synthesizer 3 and the mode field
// of synthesizer 2 channel d
// assumes synthTick and baseTick are one-cycle enables at the
// synthesizer output and base rates, and chanD3Clock is a level
// synchronous to clock
//
// How it works
// - own-code select gives low-frequency 50% clock
// - other select gives one-ref-period frame pulse
// - non-special type divides by full word
// - low field counts ref periods per frame
// - channel a select map, 00 low-frequency
// - channel b select map, 01 low-frequency
// - channel c select map, 10 low-frequency
// - polarity bit zero positive, one negative
// - style zero mid boundary, one leading
// - pulse bits join ratio outside special type
// - control words read/write, reset zero
// - synth2 channel d code 11 low-frequency
// - low-frequency for 1 Hz, divider above
// - frame reference stays in same synthesizer
module spd_post_divider (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire spd_pkg::spd_reg_req_s regReq,
  input  wire logic                  synthTick,
  input  wire logic                  baseTick,
  input  wire logic                  chanD3Clock,
  output logic [7:0]                 regRdData,
  output logic [spd_pkg::NUM_CHAN-1:0] chanOut,
  output spd_pkg::spd_mode_e         synth2DMode
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  spd_pkg::spd_state_s st;       // registered state
  spd_pkg::spd_state_s next_st;  // next state

  // word index 0 is synth2 chan d, 1..3 are synth3 chan a..c
  localparam logic [7:0] REG_BASE [spd_pkg::NUM_REG] = '{
    spd_pkg::SYNTH2_CHAN_D_DIVIDER_CTRL,
    spd_pkg::SYNTH3_CHAN_A_DIVIDER_CTRL,
    spd_pkg::SYNTH3_CHAN_B_DIVIDER_CTRL,
    spd_pkg::SYNTH3_CHAN_C_DIVIDER_CTRL
  };

  logic [spd_pkg::NUM_CHAN-1:0]              divLevel;  // divider outs
  logic [spd_pkg::NUM_CHAN-1:0][23:0]        divRatio;  // ratio used
  logic [spd_pkg::NUM_CHAN-1:0]              divTick;   // rate used
  logic [spd_pkg::NUM_CHAN-1:0]              special;   // type all ones
  spd_pkg::spd_mode_e [spd_pkg::NUM_CHAN-1:0] chanMode; // per channel
  logic [spd_pkg::NUM_CHAN:0]                refNow;    // a,b,c,d now

  // siblings of synthesizer 3 only, d arriving from outside
  assign refNow = {chanD3Clock, st.out};

  // ----------------------------------------------------------------
  // per-channel mode decode and divider
  // ----------------------------------------------------------------
  for (genvar c = 0; c < spd_pkg::NUM_CHAN; c++) begin : gChan
    logic [23:0] word;  // committed control word
    logic [1:0]  sel;   // reference select
    assign word = st.active[c+1];
    assign sel  = word[spd_pkg::SEL_HI:spd_pkg::SEL_LO];
    assign special[c] =
      (word[spd_pkg::TYPE_HI:spd_pkg::TYPE_LO] == spd_pkg::TYPE_SPECIAL);

    // own code equals the channel index: a=00, b=01, c=10
    always_comb begin
      if (!special[c]) begin
        chanMode[c] = spd_pkg::MODE_DIV;
      end else if (sel == 2'(c)) begin
        chanMode[c] = spd_pkg::MODE_LOWFREQ;
      end else begin
        chanMode[c] = spd_pkg::MODE_FRAME;
      end
    end

    // low-frequency mode runs off the base rate and low field,
    // regular mode off the output rate and the whole word
    assign divRatio[c] = special[c] ?
      {8'h00, word[spd_pkg::CNT_W-1:0]} : word;
    assign divTick[c]  = special[c] ? baseTick : synthTick;

    spd_divider uDiv (
      .clock (clock),
      .nrst  (nrst),
      .tick  (divTick[c]),
      .ratio (divRatio[c]),
      .level (divLevel[c])
    );
  end

  // ----------------------------------------------------------------
  // synthesizer 2 channel d: mode field only
  // ----------------------------------------------------------------
  always_comb begin
    if (st.active[0][spd_pkg::TYPE_HI:spd_pkg::TYPE_LO]
        != spd_pkg::TYPE_SPECIAL) begin
      synth2DMode = spd_pkg::MODE_DIV;
    end else if (st.active[0][spd_pkg::SEL_HI:spd_pkg::SEL_LO]
                 == spd_pkg::S2D_OWN_CODE) begin
      synth2DMode = spd_pkg::MODE_LOWFREQ;
    end else begin
      synth2DMode = spd_pkg::MODE_FRAME;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]  offs;       // address minus word base
    logic [1:0]  byteSel;    // 0 = msb, 2 = lsb
    logic [2:0]  newMask;    // bytes written incl. this one
    logic [23:0] word;       // committed word of a channel
    logic [1:0]  sel;        // reference select
    logic [15:0] frameLen;   // ref periods per frame
    logic        refRise;    // selected ref rose
    logic        refFall;    // selected ref fell
    logic        pulse;      // pulse before polarity
    offs     = '0;
    byteSel  = '0;
    newMask  = '0;
    word     = '0;
    sel      = '0;
    frameLen = '0;
    refRise  = 1'b0;
    refFall  = 1'b0;
    pulse    = 1'b0;
    next_st  = st;

    // -- register access --------------------------------------
    // reads answer zero unless an address hits a word
    if (regReq.read) begin
      next_st.rdData = 8'h00;
    end
    for (int i = 0; i < spd_pkg::NUM_REG; i++) begin
      offs    = regReq.addr - REG_BASE[i];
      byteSel = offs[1:0];
      if (offs < 8'h03) begin
        // msb at the lowest address of the three
        if (regReq.read) begin
          next_st.rdData =
            st.ctrl[i][(5'd16 - 5'(byteSel) * 5'd8) +: 8];
        end
        if (regReq.write) begin
          next_st.ctrl[i][(5'd16 - 5'(byteSel) * 5'd8) +: 8] =
            regReq.wrData;
          newMask = st.wrMask[i] | (3'b001 << byteSel);
          // half-written words never reach the channel logic,
          // so a reload cannot glitch a running output
          if (newMask == 3'b111) begin
            next_st.active[i] = next_st.ctrl[i];
            next_st.wrMask[i] = 3'b000;
          end else begin
            next_st.wrMask[i] = newMask;
          end
        end
      end
    end

    // -- channel outputs --------------------------------------
    next_st.refLast = refNow;
    for (int c = 0; c < spd_pkg::NUM_CHAN; c++) begin
      word     = st.active[c+1];
      sel      = word[spd_pkg::SEL_HI:spd_pkg::SEL_LO];
      frameLen = word[spd_pkg::CNT_W-1:0];
      // code k picks channel k (a,b,c,d); own code never lands
      // here because it means low-frequency mode
      refRise  = refNow[sel] & ~st.refLast[sel];
      refFall  = ~refNow[sel] & st.refLast[sel];
      if (chanMode[c] != spd_pkg::MODE_FRAME) begin
        // clock modes come straight from the divider
        next_st.out[c]      = divLevel[c];
        next_st.frmCnt[c]   = '0;
        next_st.midPulse[c] = 1'b0;
      end else begin
        if (frameLen == 16'h0000) begin
          // no frame length: pulse stays inactive
          next_st.frmCnt[c]   = '0;
          next_st.midPulse[c] = 1'b0;
        end else begin
          if (refRise) begin
            // frame boundary is the rise that wraps the count
            if (st.frmCnt[c] >= frameLen - 16'h0001) begin
              next_st.frmCnt[c] = '0;
            end else begin
              next_st.frmCnt[c] = st.frmCnt[c] + 16'h0001;
            end
          end
          if (refFall) begin
            // straddles the boundary: from the fall before the
            // wrapping rise to the fall after it
            next_st.midPulse[c] =
              (st.frmCnt[c] == frameLen - 16'h0001);
          end
        end
        if (frameLen == 16'h0000) begin
          pulse = 1'b0;
        end else if (word[spd_pkg::STYLE_B]) begin
          // leading style: one ref period from the boundary rise
          pulse = (next_st.frmCnt[c] == 16'h0000);
        end else begin
          pulse = next_st.midPulse[c];
        end
        next_st.out[c] = pulse ^ word[spd_pkg::POL_B];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;  // every control word starts at zero
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData = st.rdData;
  assign chanOut   = st.out;

endmodule : spd_post_divider

// ### bench/spd_post_divider_properties.sv
// port checker of the post-divider channels, bound onto the block
// assumes one clock domain and the byte map at 0xa1..0xac
module spd_checker (
  input wire logic                         clock,
  input wire logic                         nrst,
  input wire spd_pkg::spd_reg_req_s        regReq,
  input wire logic                         synthTick,
  input wire logic                         baseTick,
  input wire logic                         chanD3Clock,
  input wire logic [7:0]                   regRdData,
  input wire logic [spd_pkg::NUM_CHAN-1:0] chanOut,
  input wire spd_pkg::spd_mode_e           synth2DMode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // --------------------------------------------------------------
  // shadow of written and committed words
  // --------------------------------------------------------------
  logic [3:0][23:0]   sw, act;     // software view, committed
  logic [3:0][2:0]    msk;         // bytes written so far
  logic [23:0]        nw;          // word with this write applied
  logic [7:0]         off, rb;     // map offset, readback byte
  logic [1:0]         wi, bi;      // word and byte index
  logic               hit;         // address is mapped
  logic [2:0]         spec, own, divm, tk, slow;
  spd_pkg::spd_mode_e modeD;       // expected synth2 d decode
  assign hit = regReq.addr >= 8'hA1 && regReq.addr <= 8'hAC;
  assign off = regReq.addr - 8'hA1;
  assign wi  = 2'(off / 8'h03);
  assign bi  = 2'(off % 8'h03);
  // byte lane mux, msb at the lowest address
  always_comb begin
    nw = sw[wi];
    nw[8*(2-bi) +: 8] = regReq.wrData;
    rb = sw[wi][8*(2-bi) +: 8];
    modeD = spd_pkg::MODE_DIV;
    if (act[0][23:20] == 4'hF) begin
      modeD = act[0][17:16] == 2'h3 ? spd_pkg::MODE_LOWFREQ
                                    : spd_pkg::MODE_FRAME;
    end
  end
  // commit only once all three bytes arrived, so no torn word
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sw  <= '0;
      act <= '0;
      msk <= '0;
    end else if (regReq.write && hit) begin
      sw[wi]  <= nw;
      msk[wi] <= msk[wi] | (3'h1 << bi);
      if ((msk[wi] | (3'h1 << bi)) == 3'h7) begin
        act[wi] <= nw;
        msk[wi] <= '0;
      end
    end
  end
  // --------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------
  sequence s_quiet(int g);
    ($stable(act[g+1]) && divm[g])[*4];
  endsequence
  sequence s_frame(int g, int n);
    (spec[g] && !own[g] && act[g+1][15:0] == 16'(n))[*3];
  endsequence
  property p_rd_map;
    regReq.read && hit |=> regRdData == $past(rb);
  endproperty
  property p_rd_unmapped;
    regReq.read && !hit |=> regRdData == 8'h00;
  endproperty
  property p_rd_hold;
    !regReq.read |=> $stable(regRdData);
  endproperty
  property p_mode_d;
    synth2DMode == modeD;
  endproperty
  property p_steady(int g);
    s_quiet(g) ##0 !$past(tk[g], 2) |-> $stable(chanOut[g]);
  endproperty
  property p_off_low(int g);
    (divm[g] && slow[g])[*3] |-> !chanOut[g];
  endproperty
  property p_frame_n0(int g);
    s_frame(g, 0) |-> chanOut[g] == act[g+1][18];
  endproperty
  property p_lead_n1(int g);
    s_frame(g, 1) ##0 act[g+1][19] |-> chanOut[g] != act[g+1][18];
  endproperty
  a_rd_map: assert property (p_rd_map)
    else $error("readback byte differs from written byte");
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read byte moved without a read");
  a_mode_d: assert property (p_mode_d)
    else $error("synth2 channel d mode decode wrong");
  // per channel: a=0, b=1, c=2, own select code equals index
  for (genvar g = 0; g < 3; g++) begin : g_ch
    assign spec[g] = act[g+1][23:20] == 4'hF;
    assign own[g]  = act[g+1][17:16] == 2'(g);
    assign divm[g] = !spec[g] || own[g];
    assign tk[g]   = spec[g] ? baseTick : synthTick;
    assign slow[g] = spec[g] ? act[g+1][15:0] <= 16'h0001
                             : act[g+1] <= 24'h00_0001;
    a_steady: assert property (p_steady(g))
      else $error("divided output moved without a tick");
    a_off_low: assert property (p_off_low(g))
      else $error("output not low at ratio below two");
    a_frame_n0: assert property (p_frame_n0(g))
      else $error("frame output not idle at zero count");
    a_lead_n1: assert property (p_lead_n1(g))
      else $error("leading pulse not held at count one");
  end
endmodule : spd_checker

bind spd_post_divider spd_checker u_chk (
  .clock(clock), .nrst(nrst), .regReq(regReq),
  .synthTick(synthTick), .baseTick(baseTick), .chanD3Clock(chanD3Clock),
  .regRdData(regRdData), .chanOut(chanOut), .synth2DMode(synth2DMode));

// ### bench/testbench.sv
// self-checking bench of the post-divider channels
// assumes the package and design compiled first, checker bound
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                         clock, nrst, synthTick, baseTick;
  logic                         chanD3Clock;
  spd_pkg::spd_reg_req_s        regReq;
  logic [7:0]                   regRdData, rb;
  logic [spd_pkg::NUM_CHAN-1:0] chanOut;
  spd_pkg::spd_mode_e           synth2DMode;
  logic [31:0]                  seed = 32'h0000_e2f4;
  logic [23:0]                  w;
  int                           failures = 0, n_tests = 0;
  int                           r, n, hi, lo, pol, sty;
  logic [7:0]  base [4] = '{8'hA1, 8'hA4, 8'hA7, 8'hAA};
  logic [23:0] mw [3]   = '{24'hF3_0000, 24'hF1_0000, 24'h73_0000};
  logic [7:0]  me [3]   = '{8'h01, 8'h02, 8'h00};

  spd_post_divider uut (
    .clock(clock), .nrst(nrst), .regReq(regReq), .synthTick(synthTick),
    .baseTick(baseTick), .chanD3Clock(chanD3Clock),
    .regRdData(regRdData), .chanOut(chanOut), .synth2DMode(synth2DMode));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // odd ratios make the high half one tick longer
  function automatic int half_hi(int q);
    return q - q / 2;
  endfunction : half_hi
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_cnt
  // three bytes back to back, msb first
  task automatic wr_word(input logic [7:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      regReq.write  = 1'b1;
      regReq.addr   = a + 8'(i);
      regReq.wrData = v[8*(2-i) +: 8];
    end
    @(negedge clock);
    regReq.write = 1'b0;
  endtask : wr_word
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regReq.read = 1'b1;
    regReq.addr = a;
    @(negedge clock);
    d = regRdData;
    regReq.read = 1'b0;
  endtask : rd
  // counts ticks per output half; sel 0 synth, 1 base, 2 every cycle
  // the first two edges are dropped since the phase is unknown
  task automatic measure(input int g, input int sel,
                         output int h, output int l);
    logic        prev, t;
    logic [31:0] q;
    int          cnt, edges;
    prev = chanOut[g];
    t = 1'b0;
    cnt = 0;
    edges = 0;
    h = -1;
    l = -1;
    for (int k = 0; k < 3000 && edges < 4; k++) begin
      @(negedge clock);
      // a flip seen now was ended by the tick counted a cycle ago
      if (chanOut[g] !== prev) begin
        edges++;
        if (edges > 2 && prev) h = cnt;
        if (edges > 2 && !prev) l = cnt;
        cnt = 0;
        prev = chanOut[g];
      end
      cnt += t;
      q = rnd();
      synthTick = q[0] | (sel == 2);
      baseTick = q[1];
      if (k % 2 == 1) chanD3Clock = !chanD3Clock;
      t = sel == 1 ? baseTick : synthTick;
    end
  endtask : measure
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // watchdog far beyond the expected few thousand cycles
  initial begin
    #2_000_000;
    failures++;
    test_done();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    regReq = '0;
    synthTick = 1'b0;
    baseTick = 1'b0;
    chanD3Clock = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock) nrst = 1'b1;
    // reset value then random readback of every word
    for (int i = 0; i < 4; i++) begin
      w = 24'(rnd());
      for (int b = 0; b < 6; b++) begin
        if (b == 3) wr_word(base[i], w);
        rd(base[i] + 8'(b % 3), rb);
        chk_byte(rb, b < 3 ? 8'h00 : w[8*(5-b) +: 8]);
      end
    end
    wr_word(8'hAD, 24'hFF_FFFF);
    rd(8'hAD, rb);
    chk_byte(rb, 8'h00);
    rd(8'hA0, rb);
    chk_byte(rb, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr_word(8'hA1, mw[i]);
      chk_byte(8'(synth2DMode), me[i]);
    end
    $display("test registers done");
    // regular divider then low-frequency clock on each channel
    for (int g = 0; g < 3; g++) begin
      for (int m = 0; m < 2; m++) begin
        r = 2 + rnd() % 8;
        wr_word(base[g+1], m ? {4'hF, 2'h0, 2'(g), 16'(r)} : 24'(r));
        measure(g, m, hi, lo);
        chk_cnt(hi, half_hi(r));
        chk_cnt(lo, r / 2);
      end
    end
    wr_word(base[1], 24'h00_0001);
    measure(0, 0, hi, lo);
    chk_cnt(hi + lo, -2);
    $display("test dividers done");
    // every foreign reference has a period of four cycles here
    for (int g = 0; g < 3; g++) wr_word(base[g+1], 24'h00_0004);
    for (int g = 0; g < 3; g++) begin
      for (int s = 0; s < 4; s++) begin
        if (s == g) continue;
        n = 2 + rnd() % 3;
        pol = rnd() % 2;
        sty = rnd() % 2;
        wr_word(base[g+1], {4'hF, 1'(sty), 1'(pol), 2'(s), 16'(n)});
        measure(g, 2, hi, lo);
        chk_cnt(pol ? lo : hi, 4);
        chk_cnt(pol ? hi : lo, 4 * (n - 1));
        wr_word(base[g+1], 24'h00_0004);
      end
    end
    wr_word(base[2], 24'hFC_0001);
    repeat (8) @(negedge clock);
    chk_byte(8'(chanOut[1]), 8'h00);
    wr_word(base[2], 24'hF4_0000);
    repeat (8) @(negedge clock);
    chk_byte(8'(chanOut[1]), 8'h01);
    $display("test frames done");
    test_done();
  end
endmodule : testbench
